// *** logic/p1fs_pkg.sv ***
// Constants, register map and carrier types for the port 1 pin-function block.
// Assumes a single 250 MHz system clock and a classic Wishbone slave port.
package p1fs_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses, one aligned 32-bit word each)
  // ----------------------------------------------------------------
  localparam logic [7:0] P1FS_OFS_FUNC_SEL = 8'h00;  // port_function_select
  localparam logic [7:0] P1FS_OFS_P1_DIR   = 8'h04;  // port 1 direction
  localparam logic [7:0] P1FS_OFS_P1_DATA  = 8'h08;  // port 1 output value / pin level
  localparam logic [7:0] P1FS_OFS_P1_PULL  = 8'h0C;  // port 1 pull-up enable
  localparam logic [7:0] P1FS_OFS_P2_PIN2  = 8'h10;  // port 2 pin 2 direction and data

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int P1FS_BIT_LINE3 = 7;  // line 3 / timer V trigger on pin 7
  localparam int P1FS_BIT_LINE2 = 6;
  localparam int P1FS_BIT_LINE1 = 5;
  localparam int P1FS_BIT_LINE0 = 4;
  localparam int P1FS_BIT_TXD   = 1;  // serial transmit on port 2 pin 2
  localparam int P1FS_BIT_TIMER_OUT = 0;  // timer A clock output on pin 0
  localparam int P1FS_P2_DIR    = 0;  // bit of the port 2 pin 2 register
  localparam int P1FS_P2_DATA   = 1;

  // ----------------------------------------------------------------
  // Reserved masks and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] P1FS_FUNC_RSVD = 8'h0C;  // bits 3 and 2 read as one
  localparam logic [7:0] P1FS_PORT_RSVD = 8'h08;  // port 1 bit 3 has no pin
  localparam logic [7:0] P1FS_FUNC_RST  = 8'h00;
  localparam logic [7:0] P1FS_DIR_RST   = 8'h00;  // every pin an input
  localparam logic [7:0] P1FS_DATA_RST  = 8'h00;
  localparam logic [7:0] P1FS_PULL_RST  = 8'h00;
  localparam logic [1:0] P1FS_P2_RST    = 2'h0;

  // Control bundle for one pin
  typedef struct packed {
    logic func;  // peripheral function selected
    logic dir;   // 1 = output in general I/O use
    logic data;  // stored output value
    logic pull;  // pull-up enable
  } p1fs_pin_ctrl_type;

endpackage

// *** logic/p1fs_pin_cell.sv ***
// One pin of the mux: general I/O versus a shared peripheral function.
// Assumes the pin level is synchronous to the clock; purely combinational.
`timescale 1ns/100ps

module p1fs_pin_cell (
  input  wire p1fs_pkg::p1fs_pin_ctrl_type ctrl_i,
  input  wire logic                        periph_drives_i,
  input  wire logic                        periph_val_i,
  input  wire logic                        pin_i,
  output logic                             pin_o,
  output logic                             pin_oe_o,
  output logic                             pullup_o,
  output logic                             periph_in_o,
  output logic                             read_o
);

  // ----------------------------------------------------------------
  // Routing
  // ----------------------------------------------------------------
  // Function bit overrides direction for output enable and value; pull-up and read-back still follow direction
  assign pin_oe_o    = ctrl_i.func ? periph_drives_i : ctrl_i.dir;
  assign pin_o       = ctrl_i.func ? periph_val_i : ctrl_i.data;
  // Pull-up only meaningful on an input-direction pin
  assign pullup_o    = ctrl_i.pull & ~ctrl_i.dir;
  // Peripheral sees zero while the pin is general I/O, so no false edges
  assign periph_in_o = ctrl_i.func & pin_i;
  // Output pins read back the stored value, input pins the level
  assign read_o      = ctrl_i.dir ? ctrl_i.data : pin_i;

endmodule // p1fs_pin_cell

// *** logic/p1fs_top.sv ***
// Port 1 pin-function select with port 1 I/O registers and port 2 pin 2.
// Assumes a classic Wishbone master, synchronous pins and an external pad ring.
//
// Design decisions made here: the address map and the Wishbone register port.
`timescale 1ns/100ps

module p1fs_top (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone classic slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Port 1 pads
  input  wire logic [7:0]  port1_pin_i,
  output logic      [7:0]  port1_pin_o,
  output logic      [7:0]  port1_pin_oe_o,
  output logic      [7:0]  port1_pullup_o,
  // Port 2 pin 2 pad
  input  wire logic        port2_bit2_pin_i,
  output logic             port2_bit2_pin_o,
  output logic             port2_bit2_pin_oe_o,
  // Peripheral side
  input  wire logic        serial_tx_i,
  input  wire logic        timer_a_clock_i,
  output logic      [3:0]  ext_interrupt_o,
  output logic             timer_v_trigger_input_o
);

  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  logic [7:0] func_q;
  logic [7:0] dir_q;
  logic [7:0] data_q;
  logic [7:0] pull_q;
  logic [1:0] p2_q;
  logic       ack_q;
  logic [31:0] rdat_q;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  wire logic req      = wb_cyc_i & wb_stb_i & ~ack_q;
  wire logic wr       = req & wb_we_i & wb_sel_i[0];
  wire logic hit_func = (wb_adr_i == p1fs_pkg::P1FS_OFS_FUNC_SEL);
  wire logic hit_dir  = (wb_adr_i == p1fs_pkg::P1FS_OFS_P1_DIR);
  wire logic hit_data = (wb_adr_i == p1fs_pkg::P1FS_OFS_P1_DATA);
  wire logic hit_pull = (wb_adr_i == p1fs_pkg::P1FS_OFS_P1_PULL);
  wire logic hit_p2   = (wb_adr_i == p1fs_pkg::P1FS_OFS_P2_PIN2);

  // Masked write keeps reserved positions at their fixed value
  function automatic logic [7:0] keep_rsvd(input logic [7:0] wdat, input logic [7:0] rsvd);
    keep_rsvd = wdat & ~rsvd;
  endfunction

  // Byte view of a register with reserved bits forced to one
  function automatic logic [31:0] read_word(input logic [7:0] val, input logic [7:0] ones);
    read_word = {24'h000000, val | ones};
  endfunction

  // ----------------------------------------------------------------
  // Pin cells
  // ----------------------------------------------------------------
  logic [7:0] p1_read;
  logic [7:0] p1_periph_in;
  logic       p2_read;
  // Pin 0 is the only port 1 pin whose function drives outward
  wire logic [7:0] p1_drives = 8'h01;
  wire logic [7:0] p1_val    = {7'h00, timer_a_clock_i};
  // Pins 3..1 have no shared function; select bit 1 belongs to port 2 pin 2
  wire logic [7:0] p1_func   = {func_q[7:4], 3'b000, func_q[p1fs_pkg::P1FS_BIT_TIMER_OUT]};

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++)
    begin : g_p1
      p1fs_pin_cell u_cell (
        .ctrl_i          ('{func: p1_func[gi], dir: dir_q[gi], data: data_q[gi], pull: pull_q[gi]}),
        .periph_drives_i (p1_drives[gi]),
        .periph_val_i    (p1_val[gi]),
        .pin_i           (port1_pin_i[gi]),
        .pin_o           (port1_pin_o[gi]),
        .pin_oe_o        (port1_pin_oe_o[gi]),
        .pullup_o        (port1_pullup_o[gi]),
        .periph_in_o     (p1_periph_in[gi]),
        .read_o          (p1_read[gi])
      );
    end
  endgenerate

  // Port 2 pin 2 carries the serial transmit when selected
  p1fs_pin_cell u_p2_cell (
    .ctrl_i          ('{func: func_q[p1fs_pkg::P1FS_BIT_TXD], dir: p2_q[p1fs_pkg::P1FS_P2_DIR],
                        data: p2_q[p1fs_pkg::P1FS_P2_DATA], pull: 1'b0}),
    .periph_drives_i (1'b1),
    .periph_val_i    (serial_tx_i),
    .pin_i           (port2_bit2_pin_i),
    .pin_o           (port2_bit2_pin_o),
    .pin_oe_o        (port2_bit2_pin_oe_o),
    .pullup_o        (),
    .periph_in_o     (),
    .read_o          (p2_read)
  );

  // ----------------------------------------------------------------
  // Peripheral inputs
  // ----------------------------------------------------------------
  // Gated to zero while a pin is general I/O
  assign ext_interrupt_o         = p1_periph_in[7:4];
  assign timer_v_trigger_input_o = p1_periph_in[p1fs_pkg::P1FS_BIT_LINE3];

  // ----------------------------------------------------------------
  // Read selection
  // ----------------------------------------------------------------
  // Direction reads back for debug; its reserved bit stays zero
  wire logic [31:0] rd_mux =
      hit_func ? read_word(func_q, p1fs_pkg::P1FS_FUNC_RSVD) :
      hit_dir  ? read_word(dir_q, 8'h00) :
      hit_data ? read_word(p1_read, p1fs_pkg::P1FS_PORT_RSVD) :
      hit_pull ? read_word(pull_q, p1fs_pkg::P1FS_PORT_RSVD) :
      hit_p2   ? {30'h00000000, p2_read, p2_q[p1fs_pkg::P1FS_P2_DIR]} :
                 32'h00000000;                                             // unmapped reads zero

  // ----------------------------------------------------------------
  // Bus handshake
  // ----------------------------------------------------------------
  // Registered ack, one cycle after the request; dropped the next cycle
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_q  <= 1'b0;
      rdat_q <= 32'h00000000;
    end
    else
    begin
      ack_q  <= req;
      rdat_q <= req ? rd_mux : rdat_q;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  // Reset leaves every direction cleared so all pins start as inputs
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      func_q <= p1fs_pkg::P1FS_FUNC_RST;
      dir_q  <= p1fs_pkg::P1FS_DIR_RST;
      data_q <= p1fs_pkg::P1FS_DATA_RST;
      pull_q <= p1fs_pkg::P1FS_PULL_RST;
      p2_q   <= p1fs_pkg::P1FS_P2_RST;
    end
    else if (wr)
    begin
      if (hit_func)
        func_q <= keep_rsvd(wb_dat_i[7:0], p1fs_pkg::P1FS_FUNC_RSVD);
      if (hit_dir)
        dir_q  <= keep_rsvd(wb_dat_i[7:0], p1fs_pkg::P1FS_PORT_RSVD);
      if (hit_data)
        data_q <= keep_rsvd(wb_dat_i[7:0], p1fs_pkg::P1FS_PORT_RSVD);
      if (hit_pull)
        pull_q <= keep_rsvd(wb_dat_i[7:0], p1fs_pkg::P1FS_PORT_RSVD);
      if (hit_p2)
        p2_q   <= wb_dat_i[1:0];
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // Bus steps: a request accepted, then answered one cycle later
  sequence wr_func_s;
    wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_sel_i[0] && hit_func;
  endsequence

  sequence rd_data_s;
    wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i && hit_data;
  endsequence

  sequence rd_func_s;
    wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i && hit_func;
  endsequence

  line3_route_a: assert property (
    func_q[7] |-> !port1_pin_oe_o[7] && ext_interrupt_o[3] == port1_pin_i[7]
                  && timer_v_trigger_input_o == port1_pin_i[7])
    else $error("pin 7 not routed to line 3");

  line2_route_a: assert property (
    func_q[6] |-> !port1_pin_oe_o[6] && ext_interrupt_o[2] == port1_pin_i[6])
    else $error("pin 6 not routed to line 2");

  line1_route_a: assert property (
    func_q[5] |-> !port1_pin_oe_o[5] && ext_interrupt_o[1] == port1_pin_i[5])
    else $error("pin 5 not routed to line 1");

  line0_gpio_a: assert property (
    !func_q[4] |-> ext_interrupt_o[0] == 1'b0 && port1_pin_oe_o[4] == dir_q[4])
    else $error("pin 4 leaks to line 0 in general use");

  serial_tx_a: assert property (
    func_q[1] |-> port2_bit2_pin_oe_o && port2_bit2_pin_o == serial_tx_i)
    else $error("port 2 pin 2 not driven by serial transmit");

  timer_out_a: assert property (
    func_q[0] |-> port1_pin_oe_o[0] && port1_pin_o[0] == timer_a_clock_i)
    else $error("pin 0 not driven by timer A clock");

  rsvd_ones_a: assert property (
    rd_func_s |=> wb_ack_o && wb_dat_o[3:2] == 2'b11)
    else $error("reserved select bits not read as one");

  reset_inputs_a: assert property (
    $fell(rst_i) |-> port1_pin_oe_o == 8'h00 && !port2_bit2_pin_oe_o)
    else $error("pin driven right after reset");

  gpio_dir_a: assert property (
    !func_q[2] |-> port1_pin_oe_o[2] == dir_q[2] && port1_pin_o[2] == data_q[2])
    else $error("pin 2 direction not obeyed");

  data_read_a: assert property (
    rd_data_s ##0 (!dir_q[6] && !func_q[6]) |=> wb_ack_o && wb_dat_o[6] == $past(port1_pin_i[6]))
    else $error("input pin level not read back");

  pullup_dir_a: assert property (
    dir_q[5] |-> !port1_pullup_o[5])
    else $error("pull-up on output-direction pin");

  func_wins_a: assert property (
    func_q[7] && dir_q[7] |-> !port1_pin_oe_o[7])
    else $error("direction bit overrode function select");

  func_next_a: assert property (
    wr_func_s ##0 wb_dat_i[0] |=> func_q[3:2] == 2'b00 && port1_pin_o[0] == timer_a_clock_i
                                  ##1 !wb_ack_o)
    else $error("function select write misbehaved");

  pin1_gpio_a: assert property (
    func_q[1] |-> port1_pin_oe_o[1] == dir_q[1] && port1_pin_o[1] == data_q[1])
    else $error("serial select disturbed port 1 pin 1");

  line3_gate_a: assert property (
    !func_q[7] |-> !ext_interrupt_o[3] && !timer_v_trigger_input_o)
    else $error("pin 7 leaks to line 3 in general use");

  line2_gate_a: assert property (
    !func_q[6] |-> !ext_interrupt_o[2] && port1_pin_oe_o[6] == dir_q[6])
    else $error("pin 6 leaks to line 2 in general use");

  line1_gate_a: assert property (
    !func_q[5] |-> !ext_interrupt_o[1] && port1_pin_oe_o[5] == dir_q[5])
    else $error("pin 5 leaks to line 1 in general use");

  serial_gpio_a: assert property (
    !func_q[1] |-> port2_bit2_pin_oe_o == p2_q[p1fs_pkg::P1FS_P2_DIR] && port2_bit2_pin_o == p2_q[p1fs_pkg::P1FS_P2_DATA])
    else $error("port 2 pin 2 not general I/O");

  timer_gpio_a: assert property (
    !func_q[0] |-> port1_pin_oe_o[0] == dir_q[0] && port1_pin_o[0] == data_q[0])
    else $error("pin 0 not general I/O");

  pullup_on_a: assert property (
    !dir_q[4] |-> port1_pullup_o[4] == pull_q[4])
    else $error("pull-up not obeyed on input pin");

  data_hold_a: assert property (
    rd_data_s ##0 (dir_q[4] && !func_q[4]) |=> wb_ack_o && wb_dat_o[4] == data_q[4])
    else $error("stored output value not read back");

  rsvd_store_a: assert property (
    func_q[3:2] == 2'b00)
    else $error("reserved select bits stored");

  ack_once_a: assert property (
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");

endmodule // p1fs_top

// *** verif/p1fs_far_model.sv ***
// Far side of port 1 and port 2 pin 2: pads, outside drivers, peripherals.
// Assumes the device pads on one system clock; bit 8 is port 2 pin 2.
`timescale 1ns/100ps

module p1fs_far_model (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic [8:0] pin_i,
  input  wire logic [8:0] oe_i,
  input  wire logic [8:0] pull_i,
  input  wire logic [8:0] ext_val_i,
  input  wire logic [8:0] ext_en_i,
  output logic      [8:0] lvl_o,
  output logic            serial_tx_o,
  output logic            timer_a_clock_o
);
  logic [8:0] flt_q;
  logic [2:0] cnt_q;

  // ----------------------------------------------------------------
  // Pad resolution
  // ----------------------------------------------------------------
  // Device first, then outside driver, then pull-up, else floating
  assign lvl_o = (oe_i & pin_i) | (~oe_i & ext_en_i & ext_val_i) | (~oe_i & ~ext_en_i & (pull_i | flt_q));
  assign timer_a_clock_o = cnt_q[0];  // Toggles every cycle
  assign serial_tx_o     = cnt_q[2];

  // Floating lines swing each cycle so a stale level never passes
  always_ff @(posedge clk_i)
  begin
    flt_q <= rst_i ? 9'h000 : ~lvl_o;
    cnt_q <= rst_i ? 3'h0 : cnt_q + 3'h1;
  end
endmodule // p1fs_far_model

// *** verif/p1fs_top_test.sv ***
// Self-checking bench for the port 1 pin-function block.
// Assumes the far-side model and a classic Wishbone master in this file.
`timescale 1ns/100ps

module p1fs_top_test;
  localparam logic [7:0] FS = p1fs_pkg::P1FS_OFS_FUNC_SEL;
  localparam logic [7:0] DR = p1fs_pkg::P1FS_OFS_P1_DIR;
  localparam logic [7:0] DT = p1fs_pkg::P1FS_OFS_P1_DATA;
  localparam logic [7:0] PU = p1fs_pkg::P1FS_OFS_P1_PULL;
  localparam logic [7:0] P2 = p1fs_pkg::P1FS_OFS_P2_PIN2;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, ack;
  logic [7:0]  adr = 8'h00, p1_o, p1_oe, p1_pu;
  logic [31:0] wdat = 32'h0, rdat;
  logic [8:0]  lvl, ext_val = 9'h000, ext_en = 9'h000;
  logic        p2_o, p2_oe, tx, tmr, trig;
  logic [3:0]  irq;
  int          fails = 0, n_compared = 0;

  always #2 clk_i = ~clk_i;

  p1fs_top p1fs_top_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .port1_pin_i(lvl[7:0]), .port1_pin_o(p1_o), .port1_pin_oe_o(p1_oe), .port1_pullup_o(p1_pu),
    .port2_bit2_pin_i(lvl[8]), .port2_bit2_pin_o(p2_o), .port2_bit2_pin_oe_o(p2_oe),
    .serial_tx_i(tx), .timer_a_clock_i(tmr), .ext_interrupt_o(irq), .timer_v_trigger_input_o(trig));

  p1fs_far_model p1fs_far_model_i (.clk_i(clk_i), .rst_i(rst_i), .pin_i({p2_o, p1_o}),
    .oe_i({p2_oe, p1_oe}), .pull_i({1'b0, p1_pu}), .ext_val_i(ext_val), .ext_en_i(ext_en),
    .lvl_o(lvl), .serial_tx_o(tx), .timer_a_clock_o(tmr));

  // ----------------------------------------------------------------
  // Bus cycles and comparison
  // ----------------------------------------------------------------
  task automatic conclude();
    if (fails == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_compared++;
    if (got !== exp)
    begin
      fails++;
      $display("BAD %0t %s got %0h exp %0h", $time, what, got, exp);
    end
  endtask

  // Request held until ack is seen; a lost ack ends the run
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [31:0] r);
    int n;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h0, d};
    for (n = 0; n < 20; n++)
    begin
      @(posedge clk_i);
      if (ack === 1'b1)
        break;
    end
    r = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n == 20)
    begin
      fails++;
      conclude();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] r;
    wb(1'b1, a, d, r);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e, input string what);
    logic [31:0] r;
    wb(1'b0, a, 8'h00, r);
    chk(r, {24'h0, e}, what);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    rd_chk(FS, 8'h0C, "select reset");
    rd_chk(DR, 8'h00, "dir reset");
    @(negedge clk_i);
    chk({p2_oe, p1_oe}, 9'h000, "all inputs");
    chk(irq, 4'h0, "no line");
  endtask

  // Outputs keep stored data, inputs show the pad whatever is stored
  task automatic t_gpio();
    @(posedge clk_i);
    ext_en <= 9'h0FF;
    ext_val <= 9'h03C;
    wr(DR, 8'hF0);
    wr(DT, 8'hA5);
    @(negedge clk_i);
    chk(p1_oe & 8'hF7, 8'hF0, "oe");
    chk(p1_o & 8'hF0, 8'hA0, "out");
    chk({trig, irq}, 5'h00, "gated");
    rd_chk(DT, 8'hAC, "data mix");
    @(posedge clk_i);
    ext_val <= 9'h0C3;
    rd_chk(DT, 8'hAB, "pin follow");
    wr(P2, 8'h03);
    @(negedge clk_i);
    chk({p2_oe, p2_o}, 2'b11, "p2 out");
    rd_chk(P2, 8'h03, "p2 read");
  endtask

  task automatic t_pull();
    @(posedge clk_i);
    ext_en <= 9'h000;
    wr(PU, 8'hFF);
    wr(DR, 8'h0F);
    @(negedge clk_i);
    chk(p1_pu & 8'hF7, 8'hF0, "pull gate");
    rd_chk(DT, 8'hFD, "pulled high");
    wr(PU, 8'h00);
  endtask

  // Each line selected in turn with every direction bit set
  task automatic t_func();
    int i;
    wr(DR, 8'hFF);
    ext_en <= 9'h0FF;
    ext_val <= 9'h0FF;
    for (i = 4; i < 8; i++)
    begin
      wr(FS, 8'h01 << i);
      @(negedge clk_i);
      chk(p1_oe[i], 1'b0, "func wins");
      chk(irq, 4'h1 << (i - 4), "line route");
      chk(trig, i == 7, "trigger");
      rd_chk(FS, (8'h01 << i) | 8'h0C, "select read");
    end
    @(posedge clk_i);
    ext_val <= 9'h000;
    @(negedge clk_i);
    chk({trig, irq}, 5'h00, "line follows pin");
    wr(FS, 8'h00);
    @(negedge clk_i);
    chk(p1_oe & 8'hF7, 8'hF7, "back to output");
  endtask

  task automatic t_outs();
    int k;
    wr(DR, 8'h02);
    wr(P2, 8'h00);
    wr(FS, 8'h03);
    for (k = 0; k < 4; k++)
    begin
      @(negedge clk_i);
      chk({p1_oe[0], p1_o[0]}, {1'b1, tmr}, "timer out");
      chk({p2_oe, p2_o}, {1'b1, tx}, "serial out");
    end
    chk(p1_oe[1], 1'b1, "pin 1 general");
    wr(FS, 8'h00);
    @(negedge clk_i);
    chk({p1_oe[0], p2_oe}, 2'b00, "released");
  endtask

  // Reserved bits and an unmapped word must not disturb the select
  task automatic t_rsvd();
    wr(FS, 8'hF3);
    rd_chk(FS, 8'hFF, "rsvd set");
    wr(FS, 8'h00);
    wr(8'h40, 8'hFF);
    rd_chk(8'h40, 8'h00, "unmapped");
    rd_chk(FS, 8'h0C, "no alias");
  endtask

  initial
  begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_gpio();
    t_pull();
    t_func();
    t_outs();
    t_rsvd();
    conclude();
  end
endmodule // p1fs_top_test
